// file: core/asr_pkg.sv
// Shared constants, types and decode functions of the angle sensor register bank
package asr_pkg;
  localparam logic [4:0] FRAME_COUNT = 5'h10;
  localparam logic [4:0] COUNT_SAT = 5'h1f;
  localparam int RW_BIT = 15;
  localparam logic [13:0] ADDR_DUMMY = 14'h0000;
  localparam logic [13:0] ADDR_FAULT = 14'h335a;
  localparam logic [13:0] ADDR_CLEAR = 14'h3380;
  localparam logic [13:0] ADDR_SETUP = 14'h3f20;
  localparam logic [13:0] ADDR_GAIN = 14'h3ff8;
  localparam logic [13:0] ADDR_ANGLE = 14'h3fff;
  localparam int ALM_WEAK_BIT = 13;
  localparam int ALM_STRONG_BIT = 12;
  localparam int FS_WEAK = 12;
  localparam int FS_STRONG = 11;
  localparam int FS_RANGE = 10;
  localparam int FS_CALC = 9;
  localparam int FS_CONV = 8;
  localparam int FS_BUSY = 4;
  localparam int FS_ADDR = 2;
  localparam int FS_CLK = 1;
  localparam int FS_PARITY = 0;
  localparam logic [1:0] SETUP_RES_12BIT = 2'h0;
  localparam logic [8:0] SETUP_RESET = 9'h000;
  localparam logic [5:0] HOLD_RESET = 6'h00;
  localparam logic [15:0] FRAME_RESET = 16'h0000;

  typedef enum logic [1:0] {
    PH_CMD = 2'b01,
    PH_DATA = 2'b10
  } asr_phase_e;

  function automatic logic asr_known(input logic [13:0] a);
    return (a == ADDR_DUMMY) || (a == ADDR_FAULT) || (a == ADDR_CLEAR) ||
           (a == ADDR_SETUP) || (a == ADDR_GAIN) || (a == ADDR_ANGLE);
  endfunction

  // Data, flag and even parity over the upper 15 bits
  function automatic logic [15:0] asr_frame(input logic [13:0] d, input logic err_flag);
    return {d, err_flag, ^{d, err_flag}};
  endfunction
endpackage

// file: core/asr_link_if.sv
// Carrier between the serial link logic and the register core
`timescale 1ns/10ps
`default_nettype none
interface asr_link_if;
  logic [15:0] rx_word;
  logic [4:0] rx_count;
  logic [15:0] tx_word;
  modport link (output rx_word, output rx_count, input tx_word);
  modport core (input rx_word, input rx_count, output tx_word);
endinterface
`default_nettype wire

// file: core/asr_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module asr_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;

  if (WIDTH < 1) begin : g_bad
    $error("asr_pin_sync needs WIDTH of at least one");
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Hold each bit while the late stages disagree
      out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    end
  end

  assign dout = out_q;
endmodule
`default_nettype wire

// file: core/asr_spi_link.sv
// Serial link front end clocked by the host's link clock
`timescale 1ns/10ps
`default_nettype none
module asr_spi_link
  import asr_pkg::*;
(
  input wire logic sck,
  input wire logic ss_n,
  input wire logic reset_n,
  input wire logic mosi,
  output logic miso,
  asr_link_if.link lnk
);
  logic [4:0] cnt_q;
  logic [14:0] shift_q;

  // Select high clears the bit counter, so a frame always starts at bit 15
  always_ff @(posedge sck or posedge ss_n) begin
    if (ss_n) begin
      cnt_q <= 5'h00;
      shift_q <= 15'h0000;
    end else begin
      shift_q <= {shift_q[13:0], mosi};
      if (cnt_q != COUNT_SAT) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // Snapshot survives the select release; the clock is still until the next frame
  always_ff @(posedge sck or negedge reset_n) begin
    if (!reset_n) begin
      lnk.rx_word <= FRAME_RESET;
      lnk.rx_count <= 5'h00;
    end else if (!ss_n) begin
      lnk.rx_word <= {shift_q, mosi};
      lnk.rx_count <= (cnt_q == COUNT_SAT) ? cnt_q : cnt_q + 5'h01;
    end
  end

  // Response bits move after each rising edge; the host samples while the clock is low, just before the next rising edge
  assign miso = (cnt_q < FRAME_COUNT) ? lnk.tx_word[4'hf - cnt_q[3:0]] : 1'b0;
endmodule
`default_nettype wire

// file: core/asr_reg_bank.sv
// Register bank, frame decoder and error monitor of the rotary angle sensor
//
// Function
// - Clear-register read clears flag, returns zero
// - Parity, command or clock count errors set flag
// - Flag stays set until clear command
// - Address zero is dummy write, answers zero
// - Nonzero gain write holds gain constant
// - Angle register returns 12-bit angle
// - Angle bits 13/12 carry weak/strong alarms
// - Alarm pair encodes gain against limits
// - Both alarms on major error or busy
// - Setup register fields and access kinds
// - Every response carries earlier-frame error flag
// - Status bits 12/11 gain at limits
// - Status bit 10 bias headroom limit
// - Status bit 9 angle calculation overflow
// - Status bit 8 converter overflow
// - Command: read bit, address, even parity
// - Response: data, error flag, even parity
// - Status bits 2:0 address, clock, parity
// - Status bit 4 follows measurement in progress
`timescale 1ns/10ps
`default_nettype none
module asr_reg_bank
  import asr_pkg::*;
#(
  parameter logic [5:0] GAIN_MIN = 6'h00,
  parameter logic [5:0] GAIN_MAX = 6'h3f,
  // Arbitrary value
  parameter logic [2:0] SILICON_VERSION = 3'h5
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic [11:0] meas_angle,
  input wire logic [5:0] meas_gain,
  input wire logic meas_busy,
  input wire logic range_limit,
  input wire logic angle_calc_overflow,
  input wire logic converter_overflow,
  output logic gain_loop_hold,
  output logic [5:0] gain_loop_value,
  output logic [1:0] gain_setting,
  output logic [6:0] factory_bits,
  output logic measure_start,
  output logic comm_error_flag
);
  if (GAIN_MIN >= GAIN_MAX) begin : g_bad_limits
    $error("asr_reg_bank needs GAIN_MIN below GAIN_MAX");
  end

  asr_link_if lnk ();
  asr_phase_e phase_q;
  logic ss_s, ss_prev_q, frame_end;
  logic [15:0] rx;
  logic [13:0] addr, pend_addr_q, resp_addr_q, rd_data, angle_word, fault_word;
  logic is_rd, is_cmd, clk_bad, parity_bad, addr_bad, comm_fault, frame_ok;
  logic clear_cmd, dummy_cmd, angle_cmd, write_cmd, write_en;
  logic tx_load_q, resp_zero_q, comm_flag_q, major_err_q, start_q;
  logic parity_err_q, clk_err_q, addr_err_q;
  logic [5:0] hold_q;
  logic [8:0] setup_q;
  logic [15:0] tx_word_q;

  asr_pin_sync #(.WIDTH(1), .INIT(1'b1)) u_ss_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din(ss_n),
    .dout(ss_s)
  );

  asr_spi_link u_link (
    .sck(sck),
    .ss_n(ss_n),
    .reset_n(reset_n),
    .mosi(mosi),
    .miso(miso),
    .lnk(lnk.link)
  );

  assign miso_oe = ~ss_n;
  assign lnk.tx_word = tx_word_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ss_prev_q <= 1'b1;
    end else begin
      ss_prev_q <= ss_s;
    end
  end

  // The snapshot is stable here: the link clock stopped before select rose
  assign frame_end = ss_s & ~ss_prev_q;
  assign rx = lnk.rx_word;
  assign addr = rx[14:1];
  assign is_rd = rx[RW_BIT];
  assign parity_bad = ^rx;
  assign is_cmd = (phase_q == PH_CMD);
  assign clk_bad = (lnk.rx_count != FRAME_COUNT);
  assign addr_bad = is_cmd & ~asr_known(addr);
  assign comm_fault = frame_end & (clk_bad | parity_bad | addr_bad);
  assign frame_ok = frame_end & ~comm_fault;
  assign clear_cmd = frame_ok & is_cmd & is_rd & (addr == ADDR_CLEAR);
  assign dummy_cmd = frame_ok & is_cmd & (addr == ADDR_DUMMY);
  assign angle_cmd = frame_ok & is_cmd & is_rd & (addr == ADDR_ANGLE);
  assign write_cmd = frame_ok & is_cmd & ~is_rd & (addr != ADDR_DUMMY);
  assign write_en = frame_ok & ~is_cmd;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= PH_CMD;
    end else begin
      unique case (phase_q)
        PH_CMD: begin
          if (write_cmd) begin
            phase_q <= PH_DATA;
          end
        end
        PH_DATA: begin
          // A damaged data frame is dropped rather than retried
          if (frame_end) begin
            phase_q <= PH_CMD;
          end
        end
        default: begin
          phase_q <= PH_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_addr_q <= ADDR_DUMMY;
    end else if (write_cmd) begin
      pend_addr_q <= addr;
    end
  end

  // sticky flag, set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      comm_flag_q <= 1'b0;
    end else if (comm_fault) begin
      comm_flag_q <= 1'b1;
    end else if (clear_cmd) begin
      comm_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      parity_err_q <= 1'b0;
      clk_err_q <= 1'b0;
      addr_err_q <= 1'b0;
    end else begin
      parity_err_q <= (frame_end & parity_bad) | (parity_err_q & ~clear_cmd);
      clk_err_q <= (frame_end & clk_bad) | (clk_err_q & ~clear_cmd);
      addr_err_q <= (frame_end & addr_bad) | (addr_err_q & ~clear_cmd);
    end
  end

  // gain hold and writable setup fields; read-only targets take no write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= HOLD_RESET;
      setup_q <= SETUP_RESET;
    end else if (write_en) begin
      if (pend_addr_q == ADDR_GAIN) begin
        hold_q <= rx[7:2];
      end
      if (pend_addr_q == ADDR_SETUP) begin
        setup_q <= rx[10:2];
      end
    end
  end

  assign gain_loop_hold = |hold_q;
  assign gain_loop_value = hold_q;
  assign gain_setting = setup_q[4:3];
  assign factory_bits = {setup_q[8:5], setup_q[2:0]};

  // major error since the last measurement start, set wins
  // Cleared only after the answer has been loaded, so the next angle answer still reports it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      major_err_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= angle_cmd;
      if (meas_busy & (range_limit | angle_calc_overflow | converter_overflow)) begin
        major_err_q <= 1'b1;
      end else if (start_q) begin
        major_err_q <= 1'b0;
      end
    end
  end

  assign measure_start = start_q;
  assign comm_error_flag = comm_flag_q;

  always_comb begin
    angle_word = {2'h0, meas_angle};
    if (major_err_q | meas_busy) begin
      angle_word[ALM_WEAK_BIT] = 1'b1;
      angle_word[ALM_STRONG_BIT] = 1'b1;
    end else begin
      angle_word[ALM_WEAK_BIT] = meas_gain > GAIN_MAX;
      angle_word[ALM_STRONG_BIT] = meas_gain < GAIN_MIN;
    end
  end

  always_comb begin
    fault_word = 14'h0000;
    fault_word[FS_WEAK] = meas_gain >= GAIN_MAX;
    fault_word[FS_STRONG] = meas_gain <= GAIN_MIN;
    fault_word[FS_RANGE] = range_limit;
    fault_word[FS_CALC] = angle_calc_overflow;
    fault_word[FS_CONV] = converter_overflow;
    fault_word[FS_BUSY] = meas_busy;
    fault_word[FS_ADDR] = addr_err_q;
    fault_word[FS_CLK] = clk_err_q;
    fault_word[FS_PARITY] = parity_err_q;
  end

  always_comb begin
    case (resp_addr_q)
      ADDR_ANGLE: rd_data = angle_word;
      ADDR_FAULT: rd_data = fault_word;
      ADDR_SETUP: rd_data = {SETUP_RES_12BIT, SILICON_VERSION, setup_q};
      // While the loop runs the live gain is shown
      ADDR_GAIN: rd_data = {8'h00, (|hold_q) ? hold_q : meas_gain};
      default: rd_data = 14'h0000;
    endcase
  end

  // Register is sampled one cycle after frame end so a write shows its new value
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_load_q <= 1'b0;
      resp_zero_q <= 1'b1;
      resp_addr_q <= ADDR_DUMMY;
    end else begin
      tx_load_q <= frame_end;
      if (frame_end) begin
        resp_addr_q <= is_cmd ? addr : pend_addr_q;
        resp_zero_q <= comm_fault | dummy_cmd | clear_cmd;
      end
    end
  end

  // every response carries the flag and parity
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_word_q <= FRAME_RESET;
    end else if (tx_load_q) begin
      tx_word_q <= asr_frame(resp_zero_q ? 14'h0000 : rd_data, comm_flag_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_clear_zero: assert property (clear_cmd |-> ##2 tx_word_q == 16'h0000)
    else $error("clear read did not answer zero");
  chk_fault_flag: assert property (comm_fault |=> comm_flag_q && !$past(frame_ok))
    else $error("fault did not set the flag");
  chk_flag_sticky: assert property (comm_flag_q && !clear_cmd |=> comm_flag_q)
    else $error("flag dropped without clear");
  chk_dummy_quiet: assert property (dummy_cmd && !comm_flag_q
      |=> $stable(hold_q) && $stable(setup_q) ##1 tx_word_q == 16'h0000)
    else $error("dummy write changed state or answered nonzero");
  chk_gain_hold: assert property (write_en && pend_addr_q == ADDR_GAIN && rx[7:2] != 6'h00
      |=> gain_loop_hold && gain_loop_value == $past(rx[7:2]))
    else $error("gain hold not taken");
  chk_angle_value: assert property (angle_cmd |-> ##2 tx_word_q[13:2] == $past(meas_angle))
    else $error("angle response wrong");
  chk_double_alarm: assert property (angle_cmd ##1 meas_busy |=> tx_word_q[15:14] == 2'h3)
    else $error("busy did not raise both alarms");
  chk_clock_count: assert property (frame_end && lnk.rx_count != FRAME_COUNT
      |=> clk_err_q && comm_flag_q)
    else $error("clock count error not recorded");
  chk_resp_parity: assert property (tx_load_q |=> !(^tx_word_q) && tx_word_q[1] == $past(comm_flag_q))
    else $error("response parity or flag wrong");
  chk_busy_bit: assert property (tx_load_q && resp_addr_q == ADDR_FAULT && !resp_zero_q
      |=> tx_word_q[FS_BUSY + 2] == $past(meas_busy) && !tx_word_q[15])
    else $error("status busy or reserved bit wrong");
  chk_major_alarm: assert property (tx_load_q && resp_addr_q == ADDR_ANGLE && !resp_zero_q && major_err_q
      |=> tx_word_q[15:14] == 2'h3)
    else $error("major error did not raise both alarms");

  cov_clear: cover property (comm_flag_q ##[1:1000] clear_cmd);
  cov_write: cover property (write_cmd ##[1:1000] write_en);
  cov_angle: cover property (angle_cmd ##1 meas_busy);
  cov_major: cover property (major_err_q ##[1:1000] start_q);
endmodule
`default_nettype wire

// file: bench/asr_host_model.sv
// Host side model that runs framed transfers on the serial link
`timescale 1ns/10ps
`default_nettype none
module asr_host_model (
  output logic sck,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // MSB-first framing
  // Clock stands low between frames; data settles while the clock is low
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    ss_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = w[15-i];
      #62.5;
      r = {r[14:0], miso};
      sck = 1'b1;
      #62.5;
      sck = 1'b0;
    end
    #62.5;
    ss_n = 1'b1;
    // Released line shows the inverse so a stale value is never read
    mosi = ~mosi;
    // Gap well over eight core cycles lets the answer load
    #600;
  endtask
endmodule
`default_nettype wire

// file: bench/asr_reg_bank_tb_top.sv
// Self-checking bench of the angle sensor register bank
`timescale 1ns/10ps
`default_nettype none
module asr_reg_bank_tb_top;
  import asr_pkg::*;
  // Arbitrary value
  localparam logic [2:0] VER = 3'h3;
  logic clk, reset_n, sck, ss_n, mosi, miso, miso_oe, meas_busy, hold, mstart, flag;
  logic range_limit, angle_calc_overflow, converter_overflow;
  logic [11:0] meas_angle;
  logic [5:0] meas_gain, gval;
  logic [1:0] gset;
  logic [6:0] fbits;
  logic [15:0] rsp;
  int err_total = 0;
  int cmp_count = 0;
  int starts = 0;
  logic [5:0] gt[3] = '{6'h10, 6'h29, 6'h07};
  logic [1:0] at[3] = '{2'b00, 2'b10, 2'b01};
  logic [5:0] sg[3] = '{6'h28, 6'h08, 6'h10};
  logic [2:0] se[3] = '{3'b111, 3'b000, 3'b000};
  logic [13:0] sw[3] = '{14'h1700, 14'h0800, 14'h0010};

  asr_reg_bank #(.GAIN_MIN(6'h08), .GAIN_MAX(6'h28), .SILICON_VERSION(VER)) DUT (
    .clk(clk), .reset_n(reset_n), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .meas_angle(meas_angle), .meas_gain(meas_gain), .meas_busy(meas_busy),
    .range_limit(range_limit), .angle_calc_overflow(angle_calc_overflow),
    .converter_overflow(converter_overflow), .gain_loop_hold(hold), .gain_loop_value(gval),
    .gain_setting(gset), .factory_bits(fbits), .measure_start(mstart), .comm_error_flag(flag));
  asr_host_model host (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mstart === 1'b1) begin
      starts <= starts + 1;
    end
  end

  // even parity over the upper fifteen bits
  function automatic logic [15:0] p15(input logic [14:0] u);
    return {u, ^u};
  endfunction
  function automatic logic [15:0] fr(input logic [13:0] d, input logic err_flag);
    return p15({d, err_flag});
  endfunction
  function automatic logic [15:0] rd(input logic [13:0] a);
    return p15({1'b1, a});
  endfunction
  function automatic logic [15:0] wr(input logic [13:0] a);
    return p15({1'b0, a});
  endfunction

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic xf(input logic [15:0] w, input int n = 16);
    host.xfer(w, n, rsp);
  endtask
  task automatic setin(input logic [11:0] a, input logic [5:0] g, input logic b, input logic [2:0] e);
    @(posedge clk);
    meas_angle <= a;
    meas_gain <= g;
    meas_busy <= b;
    {range_limit, angle_calc_overflow, converter_overflow} <= e;
    @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    #1ms;
    err_total++;
    $display("[FAIL] run expected done seen timeout");
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0;
    meas_angle = '0;
    meas_gain = 6'h10;
    meas_busy = 1'b0;
    {range_limit, angle_calc_overflow, converter_overflow} = 3'b000;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("oe idle", 16'h0, {15'h0, miso_oe});
    xf(16'h0);
    xf(16'h0);
    chk("dummy", 16'h0000, rsp);
    for (int i = 0; i < 3; i++) begin
      setin(12'ha5c + 12'(i), gt[i], 1'b0, 3'b000);
      xf(rd(ADDR_ANGLE));
      xf(16'h0);
      chk("angle", fr({at[i], 12'ha5c + 12'(i)}, 1'b0), rsp);
    end
    // busy rises only after the angle command has ended
    fork
      xf(rd(ADDR_ANGLE));
      begin
        @(posedge sck);
        chk("oe drive", 16'h1, {15'h0, miso_oe});
        @(posedge ss_n);
        @(posedge clk);
        meas_busy <= 1'b1;
      end
    join
    setin(12'h123, 6'h10, 1'b0, 3'b000);
    xf(rd(ADDR_ANGLE));
    chk("busy alarm", fr({2'b11, 12'ha5e}, 1'b0), rsp);
    xf(16'h0);
    chk("alarm gone", fr({2'b00, 12'h123}, 1'b0), rsp);
    chk("starts", 16'd5, 16'(starts));
    // an error while busy shows on the next angle answer, then is gone
    setin(12'h0, 6'h10, 1'b1, 3'b010);
    setin(12'h0, 6'h10, 1'b0, 3'b000);
    xf(rd(ADDR_ANGLE));
    xf(rd(ADDR_ANGLE));
    chk("major alarm", fr({2'b11, 12'h0}, 1'b0), rsp);
    xf(16'h0);
    chk("major gone", fr({2'b00, 12'h0}, 1'b0), rsp);
    for (int i = 0; i < 3; i++) begin
      setin(12'h0, sg[i], i == 2, se[i]);
      xf(rd(ADDR_FAULT));
      xf(16'h0);
      chk("status", fr(sw[i], 1'b0), rsp);
    end
    // a converter overflow while not busy leaves the angle alarms clear and shows in status bit 8
    setin(12'h0, 6'h10, 1'b0, 3'b001);
    xf(rd(ADDR_ANGLE));
    xf(rd(ADDR_FAULT));
    chk("ovf angle", fr({2'b00, 12'h0}, 1'b0), rsp);
    xf(16'h0);
    chk("ovf status", fr(14'h0100, 1'b0), rsp);
    for (int i = 0; i < 3; i++) begin
      setin(12'h0, 6'h10, 1'b0, 3'b000);
      if (i == 0) xf(rd(ADDR_ANGLE) ^ 16'h1);
      else if (i == 1) xf(16'h0, 15);
      else xf(rd(14'h1234));
      chk("flag set", 16'h1, {15'h0, flag});
      xf(rd(ADDR_FAULT));
      chk("refused", fr(14'h0, 1'b1), rsp);
      xf(rd(ADDR_CLEAR));
      chk("status err", fr(14'(1 << i), 1'b1), rsp);
      xf(16'h0);
      chk("clear", 16'h0000, rsp);
      chk("flag clear", 16'h0, {15'h0, flag});
      xf(16'h0);
      chk("after clear", 16'h0000, rsp);
    end
    xf(wr(ADDR_GAIN));
    xf(fr(14'h0015, 1'b0));
    chk("gain old", fr(14'h0010, 1'b0), rsp);
    xf(16'h0);
    chk("gain new", fr(14'h0015, 1'b0), rsp);
    chk("gain pins", 16'h0055, {9'h0, hold, gval});
    xf(rd(ADDR_SETUP));
    xf(wr(ADDR_SETUP));
    chk("setup", fr({2'b00, VER, 9'h0}, 1'b0), rsp);
    // only the gain field changes; read-only bits are tried too
    xf(fr({2'b11, ~VER, 9'h018}, 1'b0));
    chk("setup old", fr({2'b00, VER, 9'h0}, 1'b0), rsp);
    xf(16'h0);
    chk("setup new", fr({2'b00, VER, 9'h018}, 1'b0), rsp);
    chk("setup pins", 16'h0180, {7'h0, gset, fbits});
    report_and_stop();
  end
endmodule
`default_nettype wire
